// file: mcheck_defines.vh
// Purpose: constants for the machine-check global control block
// Assumes: register addresses, field positions and reset values
// Notes: capability fields come from top-level parameters
`ifndef MCHECK_DEFINES_VH
`define MCHECK_DEFINES_VH
`define MC_ADDR_CAP 12'h179
`define MC_ADDR_STATE 12'h17A
`define MC_ADDR_GEN 12'h17B
`define MC_ADDR_EXT_BASE 12'h180
`define MC_ADDR_LEG_ADDR 12'h000
`define MC_ADDR_LEG_TYPE 12'h001
`define MC_CAP_COUNT_LO 0
`define MC_CAP_GEN_BIT 8
`define MC_CAP_EXT_BIT 9
`define MC_CAP_CORR_BIT 10
`define MC_CAP_THR_BIT 11
`define MC_CAP_EXTCNT_LO 16
`define MC_CAP_SWREC_BIT 24
`define MC_CAP_FWLOG_BIT 26
`define MC_CAP_LOCAL_BIT 27
`define MC_ST_RESTART 0
`define MC_ST_ERRPTR 1
`define MC_ST_INPROG 2
`define MC_ST_LOCAL 3
`define MC_GEN_RESET 64'h0000000000000000
`define MC_GEN_ALL_ONES 64'hFFFFFFFFFFFFFFFF
`endif

// file: mcheck_sync.v
// Purpose: two-stage reset release synchroniser
// Assumes: asynchronous active-low reset in
// Notes: output deasserts two edges after release
`timescale 1ns/1ps
module mcheck_sync (
  input wire clk,
  input wire rst_in_n,
  output wire rst_out_n
);
  reg s1_r;
  reg s2_r;
  always @(posedge clk or negedge rst_in_n)
  begin
    if (!rst_in_n)
    begin
      s1_r <= 1'b0;
      s2_r <= 1'b0;
    end
    else
    begin
      s1_r <= 1'b1;
      s2_r <= s1_r;
    end
  end
  assign rst_out_n = s2_r;
endmodule

// file: mcheck_event.v
// Purpose: detect a rising edge on a synchronised error request
// Assumes: input already on the core clock
// Notes: pulse lasts one cycle
`timescale 1ns/1ps
module mcheck_event (
  input wire clk,
  input wire rst_n,
  input wire level,
  output wire pulse
);
  reg prev_r;
  always @(posedge clk or negedge rst_n)
  begin
    if (!rst_n)
      prev_r <= 1'b0;
    else
      prev_r <= level;
  end
  assign pulse = level & ~prev_r;
endmodule

// file: mcheck_global.v
// Purpose: machine-check global capability, state and enable registers
// Assumes: software reaches registers by model register read/write ports
// Notes: error inputs come from core logic on the same clock
// Operation
// RULE1: Capability bits 7:0 give bank count
// RULE2: Capability bit 8 marks global enable present
// RULE3: Capability bit 9 marks extended registers at 180H
// RULE4: Capability bit 10 marks corrected-error signalling support
// RULE5: Capability bit 11 marks threshold status bits
// RULE6: Capability bits 23:16 give extended register count
// RULE7: Capability bit 24 marks software recovery support
// RULE8: Capability bit 26 marks firmware error logging
// RULE9: Capability bit 27 marks local delivery support
// RULE10: Capability register ignores writes
// RULE11: State bit 0 restart pointer valid
// RULE12: State bit 1 error pointer valid
// RULE13: Hardware sets in-progress; software may write it
// RULE14: Second event while in progress causes shutdown
// RULE15: State bit 3 marks local delivery
// RULE16: Nonzero state write raises protection fault
// RULE17: Global enable exists only when present; ones/zeros
// RULE18: Uncorrected error raises abort-class exception
// RULE19: Each bank tied to one hardware unit
// RULE20: Legacy mode logs type, address before exception
// RULE21: Reset clears flags; capability fixed by parameters
`timescale 1ns/1ps
`include "mcheck_defines.vh"
module mcheck_global #(
  parameter BANKS = 8,
  parameter EXT_COUNT = 0,
  parameter GEN_PRESENT = 1,
  parameter EXT_PRESENT = 0,
  parameter CORR_PRESENT = 0,
  parameter THR_PRESENT = 0,
  parameter SWREC_PRESENT = 0,
  parameter FWLOG_PRESENT = 0,
  parameter LOCAL_PRESENT = 0,
  parameter LEGACY_MODE = 0
)
(
  input wire REF_CLK,
  input wire RST_N,
  input wire RD_EN,
  input wire WR_EN,
  input wire [11:0] ADDR,
  input wire [63:0] WR_DATA,
  input wire ERR_REQ,
  input wire [BANKS-1:0] ERR_BANK,
  input wire ERR_RESTART_OK,
  input wire ERR_PTR_ASSOC,
  input wire ERR_LOCAL,
  input wire [63:0] ERR_TYPE,
  input wire [63:0] ERR_ADDR,
  output reg [63:0] RD_DATA,
  output reg RD_VALID,
  output reg PROT_FAULT,
  output reg MC_EXCEPTION,
  output reg SHUTDOWN,
  output reg [BANKS-1:0] BANK_EVENT,
  output reg FEATURES_ON
);
  wire rst_n;
  wire err_pulse;
  wire [63:0] cap;
  reg restart_r;
  reg errptr_r;
  reg inprog_r;
  reg local_r;
  reg [63:0] gen_r;
  reg [63:0] leg_type_r;
  reg [63:0] leg_addr_r;
  reg leg_state_r;
  reg leg_state_nxt;
  reg [63:0] rd_nxt;
  reg fault_nxt;
  reg map_ok;
  wire wr_state;
  wire wr_gen;
  wire take_err;
  wire raise;
  localparam EXT_SLOTS = (EXT_COUNT > 0) ? EXT_COUNT : 1;
  localparam [7:0] EXT_FIELD = EXT_COUNT[7:0];
  localparam LEG_IDLE = 1'b0;
  localparam LEG_RAISE = 1'b1;
  wire [BANKS-1:0] bank_nxt;
  wire [11:0] ext_off;
  wire ext_hit;
  wire [64*EXT_SLOTS-1:0] ext_flat;
  reg [63:0] ext_rd;
  reg restart_nxt;
  reg errptr_nxt;
  reg inprog_nxt;
  reg local_nxt;
  reg shutdown_nxt;
  reg exception_nxt;
  integer k;
  genvar g;

  mcheck_sync u_sync (
    .clk(REF_CLK),
    .rst_in_n(RST_N),
    .rst_out_n(rst_n)
  );

  mcheck_event u_event (
    .clk(REF_CLK),
    .rst_n(rst_n),
    .level(ERR_REQ),
    .pulse(err_pulse)
  );

  // Fixed by build parameters (see RULE21)
  assign cap[7:0] = BANKS[7:0]; // see RULE1
  assign cap[8] = (GEN_PRESENT != 0); // see RULE2
  assign cap[9] = (EXT_PRESENT != 0); // see RULE3
  assign cap[10] = (CORR_PRESENT != 0); // see RULE4
  assign cap[11] = (THR_PRESENT != 0); // see RULE5
  assign cap[15:12] = 4'h0;
  assign cap[23:16] = EXT_COUNT[7:0]; // see RULE6
  assign cap[24] = (SWREC_PRESENT != 0); // see RULE7
  assign cap[25] = 1'b0;
  assign cap[26] = (FWLOG_PRESENT != 0); // see RULE8
  assign cap[27] = (LOCAL_PRESENT != 0); // see RULE9
  assign cap[63:28] = 36'h000000000;

  // Nonzero state writes fault instead of updating (see RULE16)
  assign wr_state = WR_EN && (ADDR == `MC_ADDR_STATE) && (WR_DATA == 64'h0000000000000000);
  assign wr_gen = WR_EN && (ADDR == `MC_ADDR_GEN) && (GEN_PRESENT != 0);
  // Disabled features swallow the error report
  assign take_err = err_pulse && (gen_r == `MC_GEN_ALL_ONES || GEN_PRESENT == 0);
  // Legacy mode logs first, raises one cycle later (see RULE20)
  assign raise = (LEGACY_MODE != 0) ? (leg_state_r == LEG_RAISE) : take_err;

  // Extended window sits just above the fixed registers (see RULE3)
  assign ext_off = ADDR - `MC_ADDR_EXT_BASE;
  assign ext_hit = (EXT_PRESENT != 0) && (ADDR >= `MC_ADDR_EXT_BASE) && (ext_off < {4'h0, EXT_FIELD}); // see RULE6

  // One gate per bank keeps unit reports apart (see RULE19)
  generate
    for (g = 0; g < BANKS; g = g + 1)
    begin : bank_gate
      assign bank_nxt[g] = take_err & ERR_BANK[g];
    end
  endgenerate

  // Save area for the handler; hardware never loads it
  generate
    for (g = 0; g < EXT_SLOTS; g = g + 1)
    begin : ext_slot
      reg [63:0] slot_r;
      wire slot_wr;
      assign slot_wr = WR_EN && ext_hit && ({20'h00000, ext_off} == g);
      always @(posedge REF_CLK or negedge rst_n)
      begin
        if (!rst_n)
          slot_r <= 64'h0000000000000000;
        else if (slot_wr)
          slot_r <= WR_DATA;
      end
      assign ext_flat[g*64 +: 64] = slot_r;
    end
  endgenerate

  // Only the addressed slot reaches the read mux
  always @*
  begin
    ext_rd = 64'h0000000000000000;
    for (k = 0; k < EXT_SLOTS; k = k + 1)
    begin
      if ({20'h00000, ext_off} == k)
        ext_rd = ext_flat[k*64 +: 64];
    end
  end

  always @*
  begin
    map_ok = 1'b1;
    rd_nxt = 64'h0000000000000000;
    case (ADDR)
      `MC_ADDR_CAP: rd_nxt = cap;
      `MC_ADDR_STATE: rd_nxt = {60'h000000000000000, local_r, inprog_r, errptr_r, restart_r};
      `MC_ADDR_GEN:
      begin
        rd_nxt = gen_r;
        map_ok = (GEN_PRESENT != 0); // see RULE17
      end
      `MC_ADDR_LEG_TYPE:
      begin
        rd_nxt = leg_type_r;
        map_ok = (LEGACY_MODE != 0);
      end
      `MC_ADDR_LEG_ADDR:
      begin
        rd_nxt = leg_addr_r;
        map_ok = (LEGACY_MODE != 0);
      end
      default:
      begin
        rd_nxt = ext_rd;
        map_ok = ext_hit; // see RULE6
      end
    endcase
    fault_nxt = (RD_EN && !map_ok) || (WR_EN && !map_ok);
    // Capability writes are silently dropped (see RULE10)
    if (WR_EN && ADDR == `MC_ADDR_STATE && WR_DATA != 64'h0000000000000000)
      fault_nxt = 1'b1; // see RULE16
  end

  // Legacy order: log on the event, raise one edge later (see RULE20)
  always @*
  begin
    leg_state_nxt = leg_state_r;
    case (leg_state_r)
      LEG_IDLE:
      begin
        if (take_err && LEGACY_MODE != 0)
          leg_state_nxt = LEG_RAISE;
      end
      LEG_RAISE:
      begin
        // No new event can land here: edges are two cycles apart
        leg_state_nxt = LEG_IDLE;
      end
      default: leg_state_nxt = LEG_IDLE;
    endcase
  end

  // Event wins over a same-cycle software clear
  always @*
  begin
    restart_nxt = restart_r;
    errptr_nxt = errptr_r;
    inprog_nxt = inprog_r;
    local_nxt = local_r;
    shutdown_nxt = SHUTDOWN;
    exception_nxt = 1'b0;
    // Only a zero write gets here, so it clears every flag
    if (wr_state)
    begin
      restart_nxt = 1'b0;
      errptr_nxt = 1'b0;
      local_nxt = 1'b0;
      inprog_nxt = 1'b0; // see RULE13
    end
    if (raise)
    begin
      // Nested check cannot be taken; the core halts instead
      if (inprog_r)
        shutdown_nxt = 1'b1; // see RULE14
      else
      begin
        exception_nxt = 1'b1; // see RULE18
        inprog_nxt = 1'b1; // see RULE13
        restart_nxt = ERR_RESTART_OK; // see RULE11
        errptr_nxt = ERR_PTR_ASSOC; // see RULE12
        local_nxt = ERR_LOCAL && (LOCAL_PRESENT != 0); // see RULE15
      end
    end
  end

  always @(posedge REF_CLK or negedge rst_n)
  begin
    if (!rst_n)
    begin
      restart_r <= 1'b0; // see RULE21
      errptr_r <= 1'b0;
      inprog_r <= 1'b0;
      local_r <= 1'b0;
      gen_r <= `MC_GEN_RESET;
      leg_type_r <= 64'h0000000000000000;
      leg_addr_r <= 64'h0000000000000000;
      leg_state_r <= LEG_IDLE;
      RD_DATA <= 64'h0000000000000000;
      RD_VALID <= 1'b0;
      PROT_FAULT <= 1'b0;
      MC_EXCEPTION <= 1'b0;
      SHUTDOWN <= 1'b0;
      BANK_EVENT <= {BANKS{1'b0}};
      FEATURES_ON <= 1'b0;
    end
    else
    begin
      RD_VALID <= RD_EN && map_ok;
      RD_DATA <= (RD_EN && map_ok) ? rd_nxt : 64'h0000000000000000;
      PROT_FAULT <= fault_nxt;
      FEATURES_ON <= (gen_r == `MC_GEN_ALL_ONES) || (GEN_PRESENT == 0);
      // Only all-ones or all-zeros accepted; others kept (see RULE17)
      if (wr_gen && (WR_DATA == `MC_GEN_ALL_ONES || WR_DATA == 64'h0000000000000000))
        gen_r <= WR_DATA;
      // Per-unit reports tagged to their bank (see RULE19)
      BANK_EVENT <= bank_nxt;
      leg_state_r <= leg_state_nxt;
      if (take_err && LEGACY_MODE != 0)
      begin
        leg_type_r <= ERR_TYPE; // see RULE20
        leg_addr_r <= ERR_ADDR;
      end
      restart_r <= restart_nxt;
      errptr_r <= errptr_nxt;
      inprog_r <= inprog_nxt;
      local_r <= local_nxt;
      MC_EXCEPTION <= exception_nxt;
      SHUTDOWN <= shutdown_nxt;
    end
  end
endmodule

// file: mcheck_asserts.sv
// Purpose: port checks for mcheck_global
// Assumes: one clock, RST_N low idles all
// Notes: capability value is compared by the bench
`timescale 1ns/1ps
module mcheck_asserts #(parameter BANKS = 8)
(
  input wire REF_CLK,
  input wire RST_N,
  input wire RD_EN,
  input wire WR_EN,
  input wire [11:0] ADDR,
  input wire [63:0] WR_DATA,
  input wire ERR_REQ,
  input wire RD_VALID,
  input wire PROT_FAULT,
  input wire MC_EXCEPTION,
  input wire SHUTDOWN,
  input wire [BANKS-1:0] BANK_EVENT,
  input wire FEATURES_ON
);
  wire wr = WR_EN && !RD_EN;
  default clocking cb @(posedge REF_CLK);
  endclocking
  default disable iff (!RST_N);
  cap_read_a: assert property (RD_EN && !WR_EN && ADDR == 12'h179 |=> RD_VALID)
    else $error("cap read lost");
  cap_write_a: assert property (wr && ADDR == 12'h179 |=> !PROT_FAULT)
    else $error("cap write fault");
  state_fault_a: assert property (wr && ADDR == 12'h17A && WR_DATA != 64'h0 |=> PROT_FAULT)
    else $error("no state fault");
  enable_on_a: assert property (wr && ADDR == 12'h17B && &WR_DATA |=> ##[0:1] FEATURES_ON)
    else $error("enable lost");
  enable_gate_a: assert property (!FEATURES_ON [*4] |-> !MC_EXCEPTION)
    else $error("exception while off");
  exc_cause_a: assert property (MC_EXCEPTION |-> $past(ERR_REQ) || $past(ERR_REQ, 2))
    else $error("exception uncaused");
  shut_sticky_a: assert property (SHUTDOWN |=> SHUTDOWN)
    else $error("shutdown left");
  bank_onehot_a: assert property ($onehot0(BANK_EVENT))
    else $error("bank not onehot");
  cover property (MC_EXCEPTION);
  cover property ($rose(SHUTDOWN));
  cover property (PROT_FAULT);
endmodule
bind mcheck_global mcheck_asserts #(.BANKS(BANKS)) mcheck_asserts_inst (.REF_CLK(REF_CLK), .RST_N(RST_N),
  .RD_EN(RD_EN), .WR_EN(WR_EN), .ADDR(ADDR), .WR_DATA(WR_DATA), .ERR_REQ(ERR_REQ), .RD_VALID(RD_VALID),
  .PROT_FAULT(PROT_FAULT), .MC_EXCEPTION(MC_EXCEPTION), .SHUTDOWN(SHUTDOWN), .BANK_EVENT(BANK_EVENT),
  .FEATURES_ON(FEATURES_ON));

// file: tb.sv
// Purpose: self-checking bench for mcheck_global
// Assumes: 40 MHz clock, LFSR stimulus
// Notes: four banks keep patterns short
`timescale 1ns/1ps
module tb;
  localparam [63:0] CAP = {36'h0, 4'h9, 8'h03, 4'h0, 4'h3, 8'h04};
  reg REF_CLK = 0;
  reg RST_N = 0;
  reg RD_EN = 0;
  reg WR_EN = 0;
  reg ERR_REQ = 0;
  reg [11:0] ADDR = 12'h000;
  reg [63:0] WR_DATA = 64'h0;
  reg [3:0] ERR_BANK = 4'h0;
  reg [2:0] fl = 3'h0;
  reg [63:0] info = 64'h0;
  reg [15:0] lf = 16'hA782;
  reg [63:0] got;
  reg [3:0] bk;
  reg flt;
  reg seen;
  integer fails = 0;
  integer checks_done = 0;
  integer i;
  wire [63:0] RD_DATA;
  wire RD_VALID, PROT_FAULT, MC_EXCEPTION, SHUTDOWN, FEATURES_ON;
  wire [3:0] BANK_EVENT;
  always #12.5 REF_CLK = ~REF_CLK;
  mcheck_global #(.BANKS(4), .EXT_COUNT(3), .EXT_PRESENT(1), .SWREC_PRESENT(1), .LOCAL_PRESENT(1))
  mcheck_global_inst (.REF_CLK(REF_CLK), .RST_N(RST_N), .RD_EN(RD_EN), .WR_EN(WR_EN), .ADDR(ADDR), .WR_DATA(WR_DATA),
    .ERR_REQ(ERR_REQ), .ERR_BANK(ERR_BANK), .ERR_RESTART_OK(fl[0]), .ERR_PTR_ASSOC(fl[1]), .ERR_LOCAL(fl[2]),
    .ERR_TYPE(info), .ERR_ADDR(~info), .RD_DATA(RD_DATA), .RD_VALID(RD_VALID), .PROT_FAULT(PROT_FAULT),
    .MC_EXCEPTION(MC_EXCEPTION), .SHUTDOWN(SHUTDOWN), .BANK_EVENT(BANK_EVENT), .FEATURES_ON(FEATURES_ON));
  function [15:0] nx(input [15:0] v);
    nx = {v[14:0], v[15] ^ v[13] ^ v[12] ^ v[10]};
  endfunction
  function [63:0] st(input [2:0] f);
    st = {60'h0, f[2], 1'b1, f[1], f[0]};
  endfunction
  task chk(input string nm, input [63:0] e, input [63:0] g);
    begin
      checks_done = checks_done + 1;
      if (g !== e)
      begin
        fails = fails + 1;
        $display("wrong value %0s exp %h got %h", nm, e, g);
      end
    end
  endtask
  task acc(input r, input [11:0] a, input [63:0] d);
    begin
      @(posedge REF_CLK);
      RD_EN <= r;
      WR_EN <= !r;
      ADDR <= a;
      WR_DATA <= d;
      @(posedge REF_CLK);
      RD_EN <= 0;
      WR_EN <= 0;
      #1;
      got = (RD_VALID === 1'b1) ? RD_DATA : {64{1'bx}};
      flt = PROT_FAULT;
    end
  endtask
  task err(input [2:0] f, input [3:0] b);
    begin
      @(posedge REF_CLK);
      ERR_REQ <= 1;
      fl <= f;
      ERR_BANK <= b;
      info <= {4{lf}};
      seen = 0;
      repeat (4)
      begin
        @(posedge REF_CLK);
        #1;
        if (MC_EXCEPTION === 1'b1)
        begin
          seen = 1;
          bk = BANK_EVENT;
        end
      end
      @(posedge REF_CLK);
      ERR_REQ <= 0;
      @(posedge REF_CLK);
    end
  endtask
  task wrap_up;
    begin
      if (fails == 0 && checks_done > 0)
        $display("*** PASS ***");
      else
        $display("*** FAIL ***");
      $finish;
    end
  endtask
  initial
  begin
    #100000;
    fails = fails + 1;
    wrap_up;
  end
  initial
  begin
    repeat (4) @(posedge REF_CLK);
    RST_N <= 1;
    repeat (3) @(posedge REF_CLK);
    acc(1, 12'h179, 0);
    chk("cap", CAP, got);
    acc(0, 12'h179, {4{lf}});
    chk("cap wr fault", 0, flt);
    acc(1, 12'h179, 0);
    chk("cap kept", CAP, got);
    acc(1, 12'h17A, 0);
    chk("state", 0, got);
    acc(1, 12'h0FF, 0);
    chk("unmapped", 1, flt);
    err(3'b111, 4'h1);
    chk("dropped", 0, seen);
    acc(0, 12'h17B, {64{1'b1}});
    acc(0, 12'h17B, 64'h5);
    acc(1, 12'h17B, 0);
    chk("enable", {64{1'b1}}, got);
    chk("on", 1, FEATURES_ON);
    acc(0, 12'h181, {lf, ~lf, lf, ~lf});
    acc(1, 12'h181, 0);
    chk("ext slot", {lf, ~lf, lf, ~lf}, got);
    acc(1, 12'h183, 0);
    chk("ext end", 1, flt);
    for (i = 0; i < 6; i = i + 1)
    begin
      lf = nx(lf);
      acc(0, 12'h17A, {4{lf}} | 64'h10);
      chk("st fault", 1, flt);
      acc(1, 12'h17A, 0);
      chk("st kept", 0, got);
      err(lf[2:0], 4'h1 << lf[4:3]);
      chk("exc", 1, seen);
      chk("bank", 4'h1 << lf[4:3], bk);
      acc(1, 12'h17A, 0);
      chk("st", st(lf[2:0]), got);
      acc(0, 12'h17A, 0);
      chk("clr", 0, flt);
    end
    err(3'b001, 4'h2);
    err(3'b001, 4'h2);
    chk("second exc", 0, seen);
    chk("shutdown", 1, SHUTDOWN);
    wrap_up;
  end
endmodule
